//--- design/rsmc_map.svh
// Register offsets, field positions, reset values and timing counts
`ifndef RSMC_MAP_SVH
`define RSMC_MAP_SVH

// Register offsets on the plain register port
`define RSMC_SIM_EN_OFS    10'h1FD
`define RSMC_STATUS_OFS    10'h200
`define RSMC_ORIGIN_OFS    10'h201
`define RSMC_INIT_POS_OFS  10'h202

// Field positions in the status register
`define RSMC_ST_SIM_BIT    0
`define RSMC_ST_REFUSE_BIT 1
`define RSMC_ST_MOVE_BIT   2
`define RSMC_ST_DONE_BIT   3
`define RSMC_ST_RUN_BIT    4

// Reset values
`define RSMC_SIM_EN_RST    1'h0
`define RSMC_POS_RST       16'h0000

// Indicator step time and its cycle count at 40 MHz
`define RSMC_CLK_HZ        40000000
`define RSMC_LED_STEP_MS   500
`define RSMC_LED_STEP_CYC  ((`RSMC_CLK_HZ / 1000) * `RSMC_LED_STEP_MS)

`endif

//--- design/rsmc_pkg.sv
// Shared types of the simulation mode control block
package rsmc_pkg;

   // Number of motor axes and width of a position or speed word
   localparam int NUM_AXES = 4;
   localparam int POS_W    = 16;

   // Startup phase of the control block
   typedef enum logic [1:0] {
      ST_WAIT_NV,
      ST_SAMPLE,
      ST_RUN
   } rsmc_phase_e;

   // Indicator steps shown while simulation is active
   typedef enum logic [1:0] {
      LED_GREEN,
      LED_RED,
      LED_BOTH,
      LED_OFF
   } rsmc_led_step_e;

   // Two-colour power and alarm indicator
   typedef struct packed {
      logic green;
      logic red;
   } rsmc_led_s;

   // Command-side motion status from the trajectory logic
   typedef struct packed {
      logic commanded_motion_active;
      logic command_profile_done;
   } rsmc_cmd_s;

   // Motion status presented to host I/O
   typedef struct packed {
      logic commanded_motion_active;
      logic command_profile_done;
      logic motion_in_progress;
      logic motion_complete;
   } rsmc_motion_s;

   // Position or speed word
   typedef logic [POS_W-1:0] rsmc_word_t;

endpackage

//--- design/rsmc_led_seq.sv
// Power and alarm indicator sequencer
`timescale 1ns/1ps
`include "rsmc_map.svh"
module rsmc_led_seq #(
   parameter int STEP_CYC = `RSMC_LED_STEP_CYC   // Cycles per indicator step
)(
   input  wire logic              sys_clk,  // System clock
   input  wire logic              rstn,     // Asynchronous reset, active low
   input  wire logic              run,      // Block has finished startup
   input  wire logic              sim,      // Simulation mode is active
   output rsmc_pkg::rsmc_led_s    led       // Indicator drive, registered
);

   logic [31:0]              cnt_reg;   // Step timer
   rsmc_pkg::rsmc_led_step_e step_reg;  // Present step

   // Step timer and step advance, repeating while simulation runs
   always_ff @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         cnt_reg  <= 32'h0000_0000;
         step_reg <= rsmc_pkg::LED_GREEN;
      end
      else if (!(run && sim))
      begin
         cnt_reg  <= 32'h0000_0000;
         step_reg <= rsmc_pkg::LED_GREEN;
      end
      else if (cnt_reg == 32'(STEP_CYC - 1))
      begin
         cnt_reg <= 32'h0000_0000;
         case (step_reg)
            rsmc_pkg::LED_GREEN: step_reg <= rsmc_pkg::LED_RED;
            rsmc_pkg::LED_RED:   step_reg <= rsmc_pkg::LED_BOTH;
            rsmc_pkg::LED_BOTH:  step_reg <= rsmc_pkg::LED_OFF;
            default:             step_reg <= rsmc_pkg::LED_GREEN;
         endcase
      end
      else
      begin
         cnt_reg <= cnt_reg + 32'h0000_0001;
      end
   end

   // Indicator drive: green, red, both, off in simulation; green in normal mode; off before startup
   always_ff @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         led <= '0;
      end
      else if (!run)
      begin
         led <= '0;
      end
      else if (!sim)
      begin
         led.green <= 1'b1;
         led.red   <= 1'b0;
      end
      else
      begin
         case (step_reg)
            rsmc_pkg::LED_GREEN: led <= 2'b10;
            rsmc_pkg::LED_RED:   led <= 2'b01;
            rsmc_pkg::LED_BOTH:  led <= 2'b11;
            default:             led <= 2'b00;
         endcase
      end
   end

endmodule

//--- design/rsmc_top.sv
// Simulation mode control: mode latch, feedback muxing, motion status
`timescale 1ns/1ps
`include "rsmc_map.svh"

// What this block does
// - Stored parameter selects simulation mode
// - Zero disables, one enables, default zero
// - Sim startup blinks green, red, both, off
// - Motors stay excited in simulation
// - Origin setting refused during simulation
// - Initial coordinates taken from motor angles
// - Sim feedback and display follow commands
// - All operations and protection stay active
// - Origin input copies tool point, normal only
// - Sim motion flag drops with command
// - Normal motion flag waits for stopped motors
// - Sim complete rises with profile done
// - Normal complete waits for stopped motors
module rsmc_top #(
   parameter int LED_STEP_CYC = `RSMC_LED_STEP_CYC   // Cycles per indicator step
)(
   input  wire logic                  sys_clk,          // System clock, 40 MHz
   input  wire logic                  rstn,             // Power-on reset, active low
   // Register port
   input  wire logic [9:0]            reg_addr,         // Register address
   input  wire logic [15:0]           reg_wdata,        // Write data
   input  wire logic                  reg_wr,           // Write strobe
   input  wire logic                  reg_rd,           // Read strobe
   output logic [15:0]                reg_rdata,        // Read data, next cycle
   // Non-volatile parameter storage
   input  wire logic                  nv_ready,         // Storage has loaded, pin
   input  wire logic                  nv_sim_enable,    // Stored parameter, pin
   output logic                       nv_wr_en,         // Store pulse
   output logic                       nv_wr_data,       // Value to store
   // Host I/O
   input  wire logic                  set_user_origin_input, // Origin set, pin
   input  wire logic                  alarm_active,     // Protective stop request
   input  wire logic                  excite_request,   // Excitation request
   // Trajectory logic, same clock
   input  wire rsmc_pkg::rsmc_cmd_s   cmd_status,       // Command-side status
   input  wire rsmc_pkg::rsmc_word_t  cmd_position,     // Commanded position
   input  wire rsmc_pkg::rsmc_word_t  cmd_tcp_speed,    // Commanded tool speed
   input  wire rsmc_pkg::rsmc_word_t  tcp_position,     // Present tool point
   // Motor drivers, same clock
   input  wire rsmc_pkg::rsmc_word_t  motor_position,   // Measured position
   input  wire rsmc_pkg::rsmc_word_t  motor_tcp_speed,  // Measured tool speed
   input  wire rsmc_pkg::rsmc_word_t  motor_angle,      // Motor angle word
   input  wire logic [3:0]            motor_stopped,    // Per-axis stopped flag
   // Outputs
   output logic                       motor_excite,     // Motor excitation
   output logic                       protect_stop,     // Protective stop
   output rsmc_pkg::rsmc_motion_s     motion,           // Motion status to host
   output rsmc_pkg::rsmc_word_t       fb_position,      // Reported position
   output rsmc_pkg::rsmc_word_t       fb_tcp_speed,     // Reported tool speed
   output rsmc_pkg::rsmc_word_t       disp_position,    // Displayed position
   output rsmc_pkg::rsmc_word_t       user_origin,      // User coordinate origin
   output rsmc_pkg::rsmc_led_s        power_alarm_indicator, // Indicator drive
   output logic                       sim_active        // Mode in force
);

   // Synchroniser stages for pin inputs
   logic [1:0]            nv_rdy_sync_reg;   // Storage ready
   logic [1:0]            nv_val_sync_reg;   // Stored value
   logic [1:0]            org_sync_reg;      // Origin set input
   logic [1:0]            exc_sync_reg;      // Excitation request
   logic                  org_prev_reg;      // Origin input, last cycle

   // Mode and parameter state
   rsmc_pkg::rsmc_phase_e phase_reg;         // Startup phase
   logic                  sim_en_reg;        // Parameter shadow, software view
   logic                  sim_mode_reg;      // Mode latched at power-up
   logic                  origin_refused_reg;// Origin attempt refused, sticky
   rsmc_pkg::rsmc_word_t  init_pos_reg;      // Initial coordinates

   // Decoded strobes and events
   logic                  wr_sim;            // Write to the parameter
   logic                  wr_status;         // Write to the status register
   logic                  org_rise;          // Origin input rising edge
   logic                  all_stopped;       // Every axis at rest
   logic                  running;           // Startup finished
   logic                  in_prog_next;      // Motion in progress, next value
   logic                  done_next;         // Motion complete, next value

   assign wr_sim      = reg_wr && (reg_addr == `RSMC_SIM_EN_OFS);
   assign wr_status   = reg_wr && (reg_addr == `RSMC_STATUS_OFS);
   assign org_rise    = org_sync_reg[1] && !org_prev_reg;
   assign all_stopped = &motor_stopped;
   assign running     = (phase_reg == rsmc_pkg::ST_RUN);

   // Two-stage synchronisers for every pin input except alarm_active
   always_ff @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         nv_rdy_sync_reg <= 2'h0;
         nv_val_sync_reg <= 2'h0;
         org_sync_reg    <= 2'h0;
         exc_sync_reg    <= 2'h0;
         org_prev_reg    <= 1'b0;
      end
      else
      begin
         nv_rdy_sync_reg <= {nv_rdy_sync_reg[0], nv_ready};
         nv_val_sync_reg <= {nv_val_sync_reg[0], nv_sim_enable};
         org_sync_reg    <= {org_sync_reg[0], set_user_origin_input};
         exc_sync_reg    <= {exc_sync_reg[0], excite_request};
         org_prev_reg    <= org_sync_reg[1];
      end
   end

   // Startup: wait for storage, sample the parameter once, then run
   always_ff @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         phase_reg    <= rsmc_pkg::ST_WAIT_NV;
         sim_mode_reg <= `RSMC_SIM_EN_RST;
      end
      else
      begin
         case (phase_reg)
            // Storage not yet loaded
            rsmc_pkg::ST_WAIT_NV:
            begin
               if (nv_rdy_sync_reg[1])
               begin
                  phase_reg <= rsmc_pkg::ST_SAMPLE;
               end
            end
            // Latch mode once per power-up
            rsmc_pkg::ST_SAMPLE:
            begin
               sim_mode_reg <= nv_val_sync_reg[1];
               phase_reg    <= rsmc_pkg::ST_RUN;
            end
            // Mode stays fixed until the next power-up
            rsmc_pkg::ST_RUN: phase_reg <= rsmc_pkg::ST_RUN;
            default:          phase_reg <= rsmc_pkg::ST_WAIT_NV;
         endcase
      end
   end

   // Software view of the parameter; loaded from storage, then written
   always_ff @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         sim_en_reg <= `RSMC_SIM_EN_RST;
      end
      else if (wr_sim)
      begin
         sim_en_reg <= reg_wdata[0];
      end
      else if (phase_reg == rsmc_pkg::ST_SAMPLE)
      begin
         sim_en_reg <= nv_val_sync_reg[1];
      end
   end

   // Every write to the parameter is pushed to storage
   always_ff @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         nv_wr_en   <= 1'b0;
         nv_wr_data <= `RSMC_SIM_EN_RST;
      end
      else
      begin
         nv_wr_en <= wr_sim;
         if (wr_sim)
         begin
            nv_wr_data <= reg_wdata[0];
         end
      end
   end

   // Initial coordinates captured from the motor angle at startup
   always_ff @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         init_pos_reg <= `RSMC_POS_RST;
      end
      else if (phase_reg == rsmc_pkg::ST_SAMPLE)
      begin
         init_pos_reg <= motor_angle;
      end
   end

   // User origin: copy tool point in normal mode, refuse in simulation
   always_ff @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         user_origin <= `RSMC_POS_RST;
      end
      else if (running && org_rise && !sim_mode_reg)
      begin
         user_origin <= tcp_position;
      end
   end

   // Refused origin attempts are recorded; a new refusal beats a clear
   always_ff @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         origin_refused_reg <= 1'b0;
      end
      else if (running && org_rise && sim_mode_reg)
      begin
         origin_refused_reg <= 1'b1;
      end
      else if (wr_status && reg_wdata[`RSMC_ST_REFUSE_BIT])
      begin
         origin_refused_reg <= 1'b0;
      end
   end

   // Excitation and protection act the same in both modes
   always_ff @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         motor_excite <= 1'b0;
         protect_stop <= 1'b0;
      end
      else
      begin
         motor_excite <= running && exc_sync_reg[1];
         protect_stop <= alarm_active;
      end
   end

   // Feedback and display follow commands in simulation
   always_ff @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         fb_position   <= `RSMC_POS_RST;
         fb_tcp_speed  <= `RSMC_POS_RST;
         disp_position <= `RSMC_POS_RST;
      end
      else if (!running)
      begin
         fb_position   <= `RSMC_POS_RST;
         fb_tcp_speed  <= `RSMC_POS_RST;
         disp_position <= `RSMC_POS_RST;
      end
      else if (sim_mode_reg)
      begin
         fb_position   <= cmd_position;
         fb_tcp_speed  <= cmd_tcp_speed;
         disp_position <= cmd_position;
      end
      else
      begin
         fb_position   <= motor_position;
         fb_tcp_speed  <= motor_tcp_speed;
         disp_position <= motor_position;
      end
   end

   // Motion flags: sim tracks the command side, normal waits for motors
   always_comb
   begin
      in_prog_next = motion.motion_in_progress;
      done_next    = motion.motion_complete;
      if (sim_mode_reg)
      begin
         in_prog_next = cmd_status.commanded_motion_active;
         done_next    = cmd_status.command_profile_done;
      end
      else
      begin
         if (cmd_status.commanded_motion_active)
         begin
            in_prog_next = 1'b1;
         end
         else if (all_stopped)
         begin
            in_prog_next = 1'b0;
         end
         if (!cmd_status.command_profile_done)
         begin
            done_next = 1'b0;
         end
         else if (all_stopped)
         begin
            done_next = 1'b1;
         end
      end
   end

   // All four motion fields in one register, so one process drives it
   always_ff @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         motion <= '0;
      end
      else
      begin
         motion <= {cmd_status, in_prog_next, done_next};
      end
   end

   // Mode flag for host I/O
   always_ff @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         sim_active <= 1'b0;
      end
      else
      begin
         sim_active <= running && sim_mode_reg;
      end
   end

   // Register read data, valid in the cycle after the strobe
   always_ff @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         reg_rdata <= 16'h0000;
      end
      else if (reg_rd)
      begin
         case (reg_addr)
            `RSMC_SIM_EN_OFS:   reg_rdata <= {15'h0000, sim_en_reg};
            `RSMC_STATUS_OFS:   reg_rdata <= {11'h000, running,
                                              motion.motion_complete,
                                              motion.motion_in_progress,
                                              origin_refused_reg, sim_mode_reg};
            `RSMC_ORIGIN_OFS:   reg_rdata <= user_origin;
            `RSMC_INIT_POS_OFS: reg_rdata <= init_pos_reg;
            default:            reg_rdata <= 16'h0000;   // Unmapped reads as zero
         endcase
      end
      else
      begin
         reg_rdata <= 16'h0000;
      end
   end

   // Indicator sequencer
   rsmc_led_seq #(
      .STEP_CYC (LED_STEP_CYC)
   ) u_led (
      .sys_clk  (sys_clk),
      .rstn     (rstn),
      .run      (running),
      .sim      (sim_mode_reg),
      .led      (power_alarm_indicator)
   );

endmodule

//--- bench/rsmc_properties.sv
// Assertion checker for the simulation mode control block
`timescale 1ns/1ps
module rsmc_properties #(
   parameter int LED_STEP_CYC = 4   // Cycles per indicator step
)(
   input wire logic                   sys_clk,               // Clock
   input wire logic                   rstn,                  // Reset
   input wire logic                   excite_request,        // Excite pin
   input wire rsmc_pkg::rsmc_cmd_s    cmd_status,            // Command status
   input wire rsmc_pkg::rsmc_word_t   cmd_position,          // Command position
   input wire logic [3:0]             motor_stopped,         // Axes at rest
   input wire logic                   motor_excite,          // Excitation
   input wire rsmc_pkg::rsmc_motion_s motion,                // Motion status
   input wire rsmc_pkg::rsmc_word_t   fb_position,           // Feedback
   input wire rsmc_pkg::rsmc_word_t   user_origin,           // Origin
   input wire rsmc_pkg::rsmc_led_s    power_alarm_indicator, // Indicator
   input wire logic                   sim_active             // Mode in force
);
   // All checks share the one clock and reset
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rstn);

   property p_sim_move;
      sim_active && !cmd_status.commanded_motion_active |=> !motion.motion_in_progress;
   endproperty
   a_sim_move: assert property (p_sim_move)
      else $error("motion flag outlived command in sim");

   property p_sim_done;
      sim_active && cmd_status.command_profile_done |=> motion.motion_complete;
   endproperty
   a_sim_done: assert property (p_sim_done)
      else $error("complete flag late in sim");

   property p_norm_move;
      !sim_active && $fell(motion.motion_in_progress)
         |-> $past(&motor_stopped && !cmd_status.commanded_motion_active);
   endproperty
   a_norm_move: assert property (p_norm_move)
      else $error("motion flag dropped while motors ran");

   property p_norm_done;
      !sim_active && $rose(motion.motion_complete)
         |-> $past(&motor_stopped && cmd_status.command_profile_done);
   endproperty
   a_norm_done: assert property (p_norm_done)
      else $error("complete flag rose while motors ran");

   property p_fb;
      sim_active |=> fb_position == $past(cmd_position);
   endproperty
   a_fb: assert property (p_fb)
      else $error("feedback does not follow command in sim");

   property p_origin;
      sim_active |=> $stable(user_origin);
   endproperty
   a_origin: assert property (p_origin)
      else $error("origin changed in sim");

   property p_excite;
      (sim_active && excite_request)[*3] |=> motor_excite;
   endproperty
   a_excite: assert property (p_excite)
      else $error("motors not excited in sim");

   property p_led;
      power_alarm_indicator.red |-> sim_active;
   endproperty
   a_led: assert property (p_led)
      else $error("red indicator outside sim");
endmodule

//--- bench/rsmc_motor_model.sv
// Motor driver and parameter storage model
`timescale 1ns/1ps
module rsmc_motor_model #(
   parameter logic [15:0] ANGLE = 16'h2A5C   // Motor angle word
)(
   input  wire logic                sys_clk,         // Clock
   input  wire logic                rstn,            // Controller power
   input  wire rsmc_pkg::rsmc_cmd_s cmd_status,      // Command status
   input  wire logic                nv_wr_en,        // Store pulse
   input  wire logic                nv_wr_data,      // Value to store
   output logic                     nv_ready,        // Storage loaded
   output logic                     nv_sim_enable,   // Stored parameter
   output rsmc_pkg::rsmc_word_t     motor_position,  // Measured position
   output rsmc_pkg::rsmc_word_t     motor_tcp_speed, // Measured speed
   output rsmc_pkg::rsmc_word_t     motor_angle,     // Angle word
   output logic [3:0]               motor_stopped    // Axes at rest
);
   logic       stored_reg = 1'b0; // Survives power loss, default off
   logic [3:0] rdy_cnt_reg;       // Load delay after power-up
   logic [3:0] stop_cnt_reg;      // Coast time after command ends

   // Storage takes a new value only on a store pulse
   always @(posedge sys_clk)
      if (nv_wr_en)
         stored_reg <= nv_wr_data;
   // Storage loads a few cycles after power returns
   always @(posedge sys_clk or negedge rstn)
      if (!rstn)
         rdy_cnt_reg <= 4'h0;
      else if (rdy_cnt_reg != 4'h3)
         rdy_cnt_reg <= rdy_cnt_reg + 4'h1;
   assign nv_ready = (rdy_cnt_reg == 4'h3);
   // Invalid before load, so show the inverse
   assign nv_sim_enable = nv_ready ? stored_reg : ~stored_reg;

   // Motors coast, axis i rests i+4 cycles after command ends
   always @(posedge sys_clk or negedge rstn)
      if (!rstn)
         stop_cnt_reg <= 4'hF;
      else if (cmd_status.commanded_motion_active)
         stop_cnt_reg <= 4'h0;
      else if (stop_cnt_reg != 4'hF)
         stop_cnt_reg <= stop_cnt_reg + 4'h1;
   assign motor_stopped = {stop_cnt_reg > 4'h6, stop_cnt_reg > 4'h5,
                           stop_cnt_reg > 4'h4, stop_cnt_reg > 4'h3};
   // Position creeps while any axis moves
   always @(posedge sys_clk or negedge rstn)
      if (!rstn)
         motor_position <= 16'h0100;
      else if (!(&motor_stopped))
         motor_position <= motor_position + 16'h1;
   assign motor_tcp_speed = (&motor_stopped) ? 16'h0000 : 16'h0040;
   assign motor_angle = ANGLE;
endmodule

//--- bench/tb.sv
// Self-checking bench for the simulation mode control block
`timescale 1ns/1ps
`include "rsmc_map.svh"
module tb;
   localparam int          STEP  = 4;        // Shortened indicator step
   localparam logic [15:0] ANGLE = 16'h2A5C; // Motor angle word
   logic sys_clk, rstn, reg_wr, reg_rd, nv_ready, nv_sim_enable, nv_wr_en;
   logic nv_wr_data, set_user_origin_input, alarm_active, excite_request;
   logic motor_excite, protect_stop, sim_active;
   logic [9:0]             reg_addr;  // Register address
   logic [15:0]            reg_wdata, reg_rdata, rd_val;
   logic [3:0]             motor_stopped;
   rsmc_pkg::rsmc_cmd_s    cmd_status;
   rsmc_pkg::rsmc_word_t   cmd_position, cmd_tcp_speed, tcp_position, motor_position;
   rsmc_pkg::rsmc_word_t   motor_tcp_speed, motor_angle, fb_position, fb_tcp_speed;
   rsmc_pkg::rsmc_word_t   disp_position, user_origin;
   rsmc_pkg::rsmc_motion_s motion;
   rsmc_pkg::rsmc_led_s    power_alarm_indicator;
   int                     mismatches, compares, cycles = 0;

   rsmc_top #(.LED_STEP_CYC(STEP)) i_rsmc_top (.*);
   rsmc_motor_model #(.ANGLE(ANGLE)) i_rsmc_motor_model (.*);

   // 40 MHz clock
   initial
   begin
      sys_clk = 1'b0;
      forever #12.5 sys_clk = ~sys_clk;
   end

   // Hang guard
   always @(posedge sys_clk)
   begin
      cycles++;
      if (cycles == 3000)
      begin
         mismatches++;
         results();
      end
   end

   // Compare and count
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      compares++;
      if (got !== exp)
      begin
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
         mismatches++;
      end
   endtask

   // Wait edges, then settle
   task automatic tick(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask

   // One-cycle register write
   task automatic wr(input logic [9:0] a, input logic [15:0] d);
      @(posedge sys_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
   endtask

   // One-cycle register read, data in the next cycle
   task automatic rd(input logic [9:0] a);
      @(posedge sys_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      #1 rd_val = reg_rdata;
   endtask

   // Power cycle, wait for startup, check mode and start coordinates
   task automatic power(input logic [15:0] exp_sim);
      @(posedge sys_clk);
      rstn <= 1'b0;
      tick(2);
      @(posedge sys_clk);
      rstn <= 1'b1;
      rd_val = 16'h0000;
      for (int i = 0; i < 20 && rd_val[`RSMC_ST_RUN_BIT] !== 1'b1; i++)
         rd(`RSMC_STATUS_OFS);
      chk(rd_val[`RSMC_ST_RUN_BIT], 16'h1);
      chk(sim_active, exp_sim);
      rd(`RSMC_SIM_EN_OFS);
      chk(rd_val, exp_sim);
      rd(`RSMC_INIT_POS_OFS);
      chk(rd_val, ANGLE);
   endtask

   // Normal mode: origin copy, motion flags wait for stopped motors
   task automatic t_normal();
      power(16'h0);
      chk(power_alarm_indicator, 16'h2);
      chk(fb_position, motor_position);
      @(posedge sys_clk);
      set_user_origin_input <= 1'b1;
      excite_request <= 1'b1;
      tick(5);
      chk(user_origin, 16'h3333);
      chk(motor_excite, 16'h1);
      @(posedge sys_clk);
      set_user_origin_input <= 1'b0;
      cmd_status <= 2'b10;
      tick(3);
      @(posedge sys_clk);
      cmd_status <= 2'b01;
      tick(2);
      chk(motion[1:0], 16'h2);
      tick(10);
      chk(motion[1:0], 16'h1);
   endtask

   // Parameter write is stored but mode holds until power cycle
   task automatic t_param();
      wr(`RSMC_SIM_EN_OFS, 16'h0001);
      rd(10'h3FF);
      chk(rd_val, 16'h0);
      rd(`RSMC_SIM_EN_OFS);
      chk(rd_val, 16'h1);
      chk(sim_active, 16'h0);
      tick(1);
      chk(reg_rdata, 16'h0);
   endtask

   // Simulation mode after power cycle
   task automatic t_sim();
      power(16'h1);
      for (int i = 0; i < 20 && power_alarm_indicator !== 2'b01; i++)
         tick(1);
      tick(STEP);
      chk(power_alarm_indicator, 16'h3);
      tick(STEP);
      chk(power_alarm_indicator, 16'h0);
      tick(STEP);
      chk(power_alarm_indicator, 16'h2);
      @(posedge sys_clk);
      cmd_position <= 16'h4444;
      cmd_status <= 2'b10;
      tick(2);
      chk(fb_position, 16'h4444);
      chk(disp_position, 16'h4444);
      chk(fb_tcp_speed, 16'h2222);
      @(posedge sys_clk);
      cmd_status <= 2'b01;
      tick(1);
      chk(motion, 16'h5);
      @(posedge sys_clk);
      tcp_position <= 16'h5555;
      set_user_origin_input <= 1'b1;
      alarm_active <= 1'b1;
      tick(5);
      chk(user_origin, `RSMC_POS_RST);
      chk(protect_stop, 16'h1);
      chk(motor_excite, 16'h1);
      rd(`RSMC_STATUS_OFS);
      chk(rd_val[`RSMC_ST_REFUSE_BIT], 16'h1);
      wr(`RSMC_STATUS_OFS, 16'h0002);
      rd(`RSMC_STATUS_OFS);
      chk(rd_val[`RSMC_ST_REFUSE_BIT], 16'h0);
      wr(`RSMC_SIM_EN_OFS, 16'h0000);
      power(16'h0);
   endtask

   // Counts, verdict, end of run
   task automatic results();
      $display("compares %0d mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   // Main sequence
   initial
   begin
      {rstn, reg_wr, reg_rd, set_user_origin_input, alarm_active, excite_request} = '0;
      reg_addr = 10'h000;
      reg_wdata = 16'h0000;
      cmd_status = 2'b00;
      cmd_position = 16'h1111;
      cmd_tcp_speed = 16'h2222;
      tcp_position = 16'h3333;
      mismatches = 0;
      compares = 0;
      t_normal();
      t_param();
      t_sim();
      results();
   end
endmodule

bind rsmc_top rsmc_properties #(.LED_STEP_CYC(LED_STEP_CYC)) i_rsmc_properties (.*);
